/* File: slpr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Link parameter register bank: staged copy, active copy, transfer control.
// ==========================================================================
// Operation
// - Multiframe length register holds K minus one, resetting to 0x1f.
// - Converter count register is read only and always reads zero.
// - Scrambler register bit 7 enables scrambling; reset value 0x80 enables it.
// - Preemphasis register selects driver preemphasis and resets to 0x04.
module slpr_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic [7:0] cfg_bank_id,
  output logic [7:0] cfg_lane_id,
  output logic cfg_scramble_en,
  output logic [4:0] cfg_lane_count,
  output logic [7:0] cfg_frames_per_mf,
  output logic [7:0] cfg_res_ctrl,
  output logic [7:0] cfg_sub_total,
  output logic [7:0] cfg_samples,
  output logic [7:0] cfg_checksum,
  output logic cfg_driver_pdwn,
  output logic [7:0] cfg_phase_offset,
  output logic [7:0] cfg_preemphasis
);

  typedef struct packed {
    slpr_pkg::slpr_cfg_t staged;
    slpr_pkg::slpr_cfg_t active;
    logic xfer;
  } slpr_reg_st_t;

  slpr_bus_if bus ();
  slpr_reg_st_t st_ff;
  slpr_reg_st_t nxt_st;

  // ========================================================================
  // Address match: the upper address bits must be zero for any hit.
  // ========================================================================
  function automatic logic hit(input logic [12:0] addr, input logic [7:0] off);
    hit = (addr[12:8] == 5'h00) && (addr[7:0] == off);
  endfunction

  // ========================================================================
  // Serial port engine.
  // ========================================================================
  slpr_spi u_spi (
    .clock(clock),
    .reset_n(reset_n),
    .sclk(sclk),
    .csb(csb),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n),
    .bus(bus)
  );

  // ========================================================================
  // Write decode and transfer.
  // ========================================================================
  // Writes land in the staged set only, so the link never sees a half-written
  // parameter group; read-only and reserved addresses ignore writes.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.xfer = 1'b0;
    if (st_ff.xfer)
    begin
      nxt_st.active = st_ff.staged;
    end
    if (bus.wr)
    begin
      if (hit(bus.addr, slpr_pkg::OFF_BANK_ID))
      begin
        nxt_st.staged.bank_id = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_LANE_ID))
      begin
        nxt_st.staged.lane_id = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_SCR_LANE))
      begin
        nxt_st.staged.scr_lane = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_FRAMES_MF))
      begin
        nxt_st.staged.frames_mf = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_RES_CTRL))
      begin
        nxt_st.staged.res_ctrl = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_SUB_TOTAL))
      begin
        nxt_st.staged.sub_total = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_SAMPLES))
      begin
        nxt_st.staged.samples = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_CHECKSUM))
      begin
        nxt_st.staged.checksum = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_DRIVER))
      begin
        nxt_st.staged.driver = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_PHASE))
      begin
        nxt_st.staged.phase = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_PREEMPH))
      begin
        nxt_st.staged.preemph = bus.wdata;
      end
      if (hit(bus.addr, slpr_pkg::OFF_UPDATE))
      begin
        nxt_st.xfer = bus.wdata[slpr_pkg::XFER_BIT];
      end
    end
  end

  // Registered state; both copies start from the reset values.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '{staged: slpr_pkg::CFG_RST, active: slpr_pkg::CFG_RST, xfer: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // Read decode; unmapped and reserved addresses read as zero.
  // ========================================================================
  always_comb
  begin
    bus.rdata = 8'h00;
    if (hit(bus.addr, slpr_pkg::OFF_BANK_ID))
    begin
      bus.rdata = st_ff.staged.bank_id;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_LANE_ID))
    begin
      bus.rdata = st_ff.staged.lane_id;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_SCR_LANE))
    begin
      bus.rdata = st_ff.staged.scr_lane;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_OCTETS))
    begin
      bus.rdata = slpr_pkg::VAL_OCTETS;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_FRAMES_MF))
    begin
      bus.rdata = st_ff.staged.frames_mf;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_CONV_COUNT))
    begin
      bus.rdata = slpr_pkg::VAL_CONV_COUNT;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_RES_CTRL))
    begin
      bus.rdata = st_ff.staged.res_ctrl;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_SUB_TOTAL))
    begin
      bus.rdata = st_ff.staged.sub_total;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_SAMPLES))
    begin
      bus.rdata = st_ff.staged.samples;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_DENSITY))
    begin
      bus.rdata = slpr_pkg::VAL_DENSITY;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_RSVD_ONE) || hit(bus.addr, slpr_pkg::OFF_RSVD_TWO))
    begin
      bus.rdata = slpr_pkg::VAL_RSVD;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_CHECKSUM))
    begin
      bus.rdata = st_ff.staged.checksum;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_DRIVER))
    begin
      bus.rdata = st_ff.staged.driver;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_PHASE))
    begin
      bus.rdata = st_ff.staged.phase;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_PREEMPH))
    begin
      bus.rdata = st_ff.staged.preemph;
    end
    else if (hit(bus.addr, slpr_pkg::OFF_UPDATE))
    begin
      bus.rdata = {7'h00, st_ff.xfer};
    end
  end

  // ========================================================================
  // Active settings seen by the link.
  // ========================================================================
  // The link only follows the active copy, which relies on software keeping
  // the transmitter powered down around a transfer.
  assign cfg_bank_id = st_ff.active.bank_id;
  assign cfg_lane_id = st_ff.active.lane_id;
  assign cfg_scramble_en = st_ff.active.scr_lane[slpr_pkg::SCR_BIT];
  assign cfg_lane_count = st_ff.active.scr_lane[slpr_pkg::LANE_MSB:0];
  assign cfg_frames_per_mf = st_ff.active.frames_mf;
  assign cfg_res_ctrl = st_ff.active.res_ctrl;
  assign cfg_sub_total = st_ff.active.sub_total;
  assign cfg_samples = st_ff.active.samples;
  assign cfg_checksum = st_ff.active.checksum;
  assign cfg_driver_pdwn = st_ff.active.driver[slpr_pkg::DRV_PDWN_BIT];
  assign cfg_phase_offset = st_ff.active.phase;
  assign cfg_preemphasis = st_ff.active.preemph;

  // ========================================================================
  // Checks.
  // ========================================================================
  AST_K_RESET: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> (cfg_frames_per_mf == 8'h1f) && (st_ff.staged.frames_mf == 8'h1f))
    else $error("Multiframe length did not reset to 0x1f.");

  AST_M_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.addr == 13'h0071) |-> (bus.rdata == 8'h00))
    else $error("Converter count read back nonzero.");

  AST_M_NO_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.wr && bus.addr == 13'h0071) |=> $stable(st_ff.staged) && $stable(st_ff.active))
    else $error("Write to converter count changed stored settings.");

  AST_SCR_RESET: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> cfg_scramble_en && (st_ff.active.scr_lane == 8'h80))
    else $error("Scrambler not enabled after reset.");

  AST_SCR_FOLLOW: assert property (@(posedge clock) disable iff (!reset_n)
    st_ff.xfer |=> (cfg_scramble_en == $past(st_ff.staged.scr_lane[7])))
    else $error("Scrambler enable did not follow the transferred bit.");

  AST_PRE_RESET: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> (cfg_preemphasis == 8'h04))
    else $error("Preemphasis did not reset to 0x04.");

  AST_XFER_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.wr && bus.addr == 13'h00ff && bus.wdata[0]) |=> st_ff.xfer ##1 !st_ff.xfer
      && (st_ff.active == $past(st_ff.staged)))
    else $error("Transfer bit did not copy settings and clear itself.");

  AST_ACTIVE_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
    !st_ff.xfer |=> $stable(st_ff.active))
    else $error("Active settings changed without a transfer.");

  // The multiframe length, scrambler/lane and preemphasis staged registers take the byte of the strobe that hits them,
  // and each transfer carries that byte to the active copy on the next clock.
  AST_K_STAGE: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.wr && hit(bus.addr, slpr_pkg::OFF_FRAMES_MF))
      |=> (st_ff.staged.frames_mf == $past(bus.wdata)))
    else $error("Multiframe length write did not reach the staged copy.");

  AST_K_FOLLOW: assert property (@(posedge clock) disable iff (!reset_n)
    st_ff.xfer |=> (cfg_frames_per_mf == $past(st_ff.staged.frames_mf)))
    else $error("Multiframe length did not follow the transfer.");

  AST_SCR_STAGE: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.wr && hit(bus.addr, slpr_pkg::OFF_SCR_LANE))
      |=> (st_ff.staged.scr_lane == $past(bus.wdata)))
    else $error("Scrambler and lane write did not reach the staged copy.");

  AST_LANE_FOLLOW: assert property (@(posedge clock) disable iff (!reset_n)
    st_ff.xfer |=> (cfg_lane_count == $past(st_ff.staged.scr_lane[4:0])))
    else $error("Lane count did not follow the transfer.");

  AST_PRE_STAGE: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.wr && hit(bus.addr, slpr_pkg::OFF_PREEMPH))
      |=> (st_ff.staged.preemph == $past(bus.wdata)))
    else $error("Preemphasis write did not reach the staged copy.");

  AST_PRE_FOLLOW: assert property (@(posedge clock) disable iff (!reset_n)
    st_ff.xfer |=> (cfg_preemphasis == $past(st_ff.staged.preemph)))
    else $error("Preemphasis did not follow the transfer.");

  AST_XFER_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
    (st_ff.xfer && !bus.wr) |=> !st_ff.xfer)
    else $error("Transfer bit did not clear itself.");

endmodule
`default_nettype wire

/* File: slpr_pkg.sv */
`default_nettype none
// ==========================================================================
// Shared constants and types of the serial link parameter register bank.
// ==========================================================================
package slpr_pkg;

  // ========================================================================
  // Serial control port framing.
  // ========================================================================
  localparam int ADDR_W = 13;
  localparam logic [4:0] INSTR_LAST = 5'h0f;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [12:0] ADDR_STEP = 13'h0001;

  // ========================================================================
  // Register offsets.
  // ========================================================================
  localparam logic [7:0] OFF_BANK_ID = 8'h65;
  localparam logic [7:0] OFF_LANE_ID = 8'h67;
  localparam logic [7:0] OFF_SCR_LANE = 8'h6e;
  localparam logic [7:0] OFF_OCTETS = 8'h6f;
  localparam logic [7:0] OFF_FRAMES_MF = 8'h70;
  localparam logic [7:0] OFF_CONV_COUNT = 8'h71;
  localparam logic [7:0] OFF_RES_CTRL = 8'h72;
  localparam logic [7:0] OFF_SUB_TOTAL = 8'h73;
  localparam logic [7:0] OFF_SAMPLES = 8'h74;
  localparam logic [7:0] OFF_DENSITY = 8'h75;
  localparam logic [7:0] OFF_RSVD_ONE = 8'h76;
  localparam logic [7:0] OFF_RSVD_TWO = 8'h77;
  localparam logic [7:0] OFF_CHECKSUM = 8'h79;
  localparam logic [7:0] OFF_DRIVER = 8'h80;
  localparam logic [7:0] OFF_PHASE = 8'h8b;
  localparam logic [7:0] OFF_PREEMPH = 8'ha8;
  localparam logic [7:0] OFF_UPDATE = 8'hff;

  // ========================================================================
  // Field positions.
  // ========================================================================
  localparam int SCR_BIT = 7;
  localparam int LANE_MSB = 4;
  localparam int DRV_PDWN_BIT = 0;
  localparam int XFER_BIT = 0;

  // ========================================================================
  // Values after reset and fixed read-only values.
  // ========================================================================
  localparam logic [7:0] RST_BANK_ID = 8'h00;
  localparam logic [7:0] RST_LANE_ID = 8'h00;
  localparam logic [7:0] RST_SCR_LANE = 8'h80;
  localparam logic [7:0] VAL_OCTETS = 8'h01;
  localparam logic [7:0] RST_FRAMES_MF = 8'h1f;
  localparam logic [7:0] VAL_CONV_COUNT = 8'h00;
  localparam logic [7:0] RST_RES_CTRL = 8'h0d;
  localparam logic [7:0] RST_SUB_TOTAL = 8'h2f;
  localparam logic [7:0] RST_SAMPLES = 8'h20;
  localparam logic [7:0] VAL_DENSITY = 8'h00;
  localparam logic [7:0] RST_CHECKSUM = 8'h00;
  localparam logic [7:0] RST_DRIVER = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_PREEMPH = 8'h04;
  localparam logic [7:0] VAL_RSVD = 8'h00;

  // ========================================================================
  // Link configuration set, held once staged and once active.
  // ========================================================================
  typedef struct packed {
    logic [7:0] bank_id;
    logic [7:0] lane_id;
    logic [7:0] scr_lane;
    logic [7:0] frames_mf;
    logic [7:0] res_ctrl;
    logic [7:0] sub_total;
    logic [7:0] samples;
    logic [7:0] checksum;
    logic [7:0] driver;
    logic [7:0] phase;
    logic [7:0] preemph;
  } slpr_cfg_t;

  localparam slpr_cfg_t CFG_RST = '{
    bank_id: RST_BANK_ID,
    lane_id: RST_LANE_ID,
    scr_lane: RST_SCR_LANE,
    frames_mf: RST_FRAMES_MF,
    res_ctrl: RST_RES_CTRL,
    sub_total: RST_SUB_TOTAL,
    samples: RST_SAMPLES,
    checksum: RST_CHECKSUM,
    driver: RST_DRIVER,
    phase: RST_PHASE,
    preemph: RST_PREEMPH
  };

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_INSTR = 3'b010,
    SPI_DATA = 3'b100
  } slpr_spi_state_t;

endpackage
`default_nettype wire

/* File: slpr_bus_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Byte access path from the serial port engine to the register file.
// ==========================================================================
interface slpr_bus_if;
  logic wr;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport port (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: slpr_spi.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Serial control port engine: 16-bit instruction, then data bytes MSB first.
// ==========================================================================
module slpr_spi (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  slpr_bus_if.port bus
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] csb_s;
    logic [1:0] sdi_s;
    slpr_pkg::slpr_spi_state_t state;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic [12:0] addr;
    logic rnw;
    logic wr;
    logic load;
    logic sdo;
    logic oe_n;
  } slpr_spi_st_t;

  slpr_spi_st_t st_ff;
  slpr_spi_st_t nxt_st;
  logic rise;
  logic fall;
  logic sel;
  logic bit_in;

  // ========================================================================
  // Edge detection looks only at the second and third synchroniser stages.
  // ========================================================================
  assign rise = st_ff.sclk_s[1] & ~st_ff.sclk_s[2];
  assign fall = ~st_ff.sclk_s[1] & st_ff.sclk_s[2];
  assign sel = ~st_ff.csb_s[1];
  assign bit_in = st_ff.sdi_s[1];

  // Next state; the serial clock must stay several system clocks per phase.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.sclk_s = {st_ff.sclk_s[1:0], sclk};
    nxt_st.csb_s = {st_ff.csb_s[0], csb};
    nxt_st.sdi_s = {st_ff.sdi_s[0], sdio_in};
    nxt_st.wr = 1'b0;
    nxt_st.load = 1'b0;
    // A completed write steps the address down for a streamed next byte.
    if (st_ff.wr)
    begin
      nxt_st.addr = st_ff.addr - slpr_pkg::ADDR_STEP;
    end
    if (st_ff.load)
    begin
      nxt_st.shift = {bus.rdata, 8'h00};
    end
    case (st_ff.state)
      slpr_pkg::SPI_IDLE:
      begin
        nxt_st.oe_n = 1'b1;
        nxt_st.cnt = 5'h00;
        if (sel)
        begin
          nxt_st.state = slpr_pkg::SPI_INSTR;
        end
      end
      slpr_pkg::SPI_INSTR:
      begin
        if (rise)
        begin
          nxt_st.shift = {st_ff.shift[14:0], bit_in};
          nxt_st.cnt = st_ff.cnt + 5'h01;
          if (st_ff.cnt == slpr_pkg::INSTR_LAST)
          begin
            nxt_st.rnw = st_ff.shift[14];
            nxt_st.addr = {st_ff.shift[11:0], bit_in};
            nxt_st.cnt = 5'h00;
            nxt_st.load = st_ff.shift[14];
            nxt_st.state = slpr_pkg::SPI_DATA;
          end
        end
      end
      slpr_pkg::SPI_DATA:
      begin
        if (st_ff.rnw && fall)
        begin
          nxt_st.sdo = st_ff.shift[15];
          nxt_st.oe_n = 1'b0;
          nxt_st.shift = {st_ff.shift[14:0], 1'b0};
        end
        if (rise)
        begin
          nxt_st.cnt = st_ff.cnt + 5'h01;
          if (!st_ff.rnw)
          begin
            nxt_st.shift = {st_ff.shift[14:0], bit_in};
          end
          if (st_ff.cnt == slpr_pkg::BYTE_LAST)
          begin
            nxt_st.cnt = 5'h00;
            nxt_st.wr = ~st_ff.rnw;
            if (st_ff.rnw)
            begin
              nxt_st.addr = st_ff.addr - slpr_pkg::ADDR_STEP;
              nxt_st.load = 1'b1;
            end
          end
        end
      end
      default:
      begin
        nxt_st.state = slpr_pkg::SPI_IDLE;
      end
    endcase
    // Deselect aborts any partial byte and releases the data pin.
    if (!sel)
    begin
      nxt_st.state = slpr_pkg::SPI_IDLE;
      nxt_st.oe_n = 1'b1;
    end
  end

  // Registered state; chip select idles high so it resets deselected.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '{sclk_s: 3'h0, csb_s: 2'h3, sdi_s: 2'h0, state: slpr_pkg::SPI_IDLE,
                 cnt: 5'h00, shift: 16'h0000, addr: 13'h0000, rnw: 1'b0, wr: 1'b0,
                 load: 1'b0, sdo: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign bus.wr = st_ff.wr;
  assign bus.addr = st_ff.addr;
  assign bus.wdata = st_ff.shift[7:0];
  assign sdio_out = st_ff.sdo;
  assign sdio_oe_n = st_ff.oe_n;

endmodule
`default_nettype wire

/* File: slpr_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ======
// Serial control port master standing in for the host processor.
module slpr_host (
  input wire logic clock,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  output logic sclk,
  output logic csb,
  output logic sdio_in,
  output logic rd_done,
  output logic [7:0] rd_byte
);
  logic drv_bit;
  logic rel;

  // The shared data wire: device wins while it drives, else our bit.
  assign sdio_in = sdio_oe_n ? drv_bit : sdio_out;

  // A released wire has no pull, so it wanders instead of holding a value.
  always @(negedge clock)
  begin
    if (rel)
      drv_bit <= ~drv_bit;
  end

  initial
  begin
    sclk = 1'b0;
    csb = 1'b1;
    drv_bit = 1'b0;
    rel = 1'b1;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end

  // One frame: instruction then n bytes; sclk phases are five clocks each.
  task xfer(input logic rd, input logic [12:0] a, input int n, input logic [31:0] d);
    logic [47:0] sh;
    int i;
    sh = {rd, 2'b00, a, d};
    @(negedge clock);
    csb = 1'b0;
    rel = 1'b0;
    repeat (5) @(negedge clock);
    for (i = 0; i < 16 + 8 * n; i++)
    begin
      sclk = 1'b0;
      if (rd && i >= 16)
        rel = 1'b1;
      else
        drv_bit = sh[47-i];
      repeat (5) @(negedge clock);
      sclk = 1'b1;
      if (i >= 16)
        rd_byte = {rd_byte[6:0], sdio_in};
      repeat (5) @(negedge clock);
    end
    sclk = 1'b0;
    repeat (5) @(negedge clock);
    csb = 1'b1;
    rel = 1'b1;
    rd_done = rd;
    @(negedge clock);
    rd_done = 1'b0;
    repeat (5) @(negedge clock);
  endtask
endmodule
`default_nettype wire

/* File: slpr_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ======
// Self-checking bench for the link parameter register bank.
module slpr_regs_tb_top;
  logic clock, reset_n, sclk, csb, sdio_in, sdio_out, sdio_oe_n, rd_done;
  logic [7:0] rd_byte, bank_id, lane_id, k, res, sub, smp, chks, ph, pre;
  logic scr_en, pdwn;
  logic [4:0] lanes;
  logic [7:0] scr_w, pre_w, pre_exp;
  logic [15:0] p;
  logic [15:0] expq[$];
  int mismatches, cmp_count, i;
  integer seed;

  slpr_regs i_dut (.clock(clock), .reset_n(reset_n), .sclk(sclk), .csb(csb),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .cfg_bank_id(bank_id), .cfg_lane_id(lane_id), .cfg_scramble_en(scr_en),
    .cfg_lane_count(lanes), .cfg_frames_per_mf(k), .cfg_res_ctrl(res),
    .cfg_sub_total(sub), .cfg_samples(smp), .cfg_checksum(chks),
    .cfg_driver_pdwn(pdwn), .cfg_phase_offset(ph), .cfg_preemphasis(pre));

  slpr_host i_host (.clock(clock), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sclk(sclk), .csb(csb), .sdio_in(sdio_in), .rd_done(rd_done), .rd_byte(rd_byte));

  // Free-running 4 ns clock.
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task wr(input logic [12:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, 1, {d, 24'h000000});
  endtask

  // The expected byte is queued before the frame so the monitor can match it.
  task rd(input logic [12:0] a, input logic [7:0] e);
    expq.push_back({a[7:0], e});
    i_host.xfer(1'b1, a, 1, 32'h00000000);
  endtask

  task commit;
    wr(13'h0ff, 8'h01);
  endtask

  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Each finished read frame retires the oldest queued expectation.
  always @(posedge clock)
  begin
    if (rd_done === 1'b1 && expq.size() == 0)
    begin
      mismatches++;
      $display("MISMATCH readq exp entry got none");
    end
    else if (rd_done === 1'b1)
    begin
      p = expq.pop_front();
      chk($sformatf("reg %h", p[15:8]), p[7:0], rd_byte);
    end
  end

  // A full run takes about ten thousand clocks; this limit leaves wide margin.
  initial
  begin
    #200000;
    mismatches++;
    $display("MISMATCH watchdog exp done got hang");
    end_of_test();
  end

  // Main sequence: reset, defaults, staged writes, commits, refusals.
  initial
  begin
    seed = 32'hfca4fa65;
    pre_exp = 8'h04;
    reset_n = 1'b0;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    chk("k", 8'h1f, k);
    chk("scr", 8'h01, {7'h00, scr_en});
    chk("pre", 8'h04, pre);
    chk("pdwn", 8'h00, {7'h00, pdwn});
    rd(13'h070, 8'h1f);
    rd(13'h071, 8'h00);
    rd(13'h06e, 8'h80);
    rd(13'h0a8, 8'h04);
    wr(13'h080, 8'h01);
    commit();
    chk("pdwn", 8'h01, {7'h00, pdwn});
    // Descending stream: K of eight one-octet frames, read-only bytes ignored.
    i_host.xfer(1'b0, 13'h071, 4, 32'h5507aa80);
    chk("k", 8'h1f, k);
    rd(13'h071, 8'h00);
    rd(13'h070, 8'h07);
    rd(13'h06f, 8'h01);
    rd(13'h100, 8'h00);
    commit();
    chk("k", 8'h07, k);
    rd(13'h0ff, 8'h00);
    // A streamed read walks down too; the last byte comes from the K register.
    expq.push_back({8'h70, 8'h07});
    i_host.xfer(1'b1, 13'h071, 2, 32'h00000000);
    for (i = 0; i < 2; i++)
    begin
      scr_w = {~i[0], 2'b00, 5'($random(seed))};
      pre_w = 8'($random(seed));
      wr(13'h06e, scr_w);
      wr(13'h0a8, pre_w);
      chk("pre", pre_exp, pre);
      commit();
      pre_exp = pre_w;
      chk("scr", {7'h00, scr_w[7]}, {7'h00, scr_en});
      chk("lanes", {3'h0, scr_w[4:0]}, {3'h0, lanes});
      chk("pre", pre_w, pre);
      rd(13'h06e, scr_w);
    end
    // Remaining parameters: defaults first, then staged values held until a commit.
    chk("bid", 8'h00, bank_id);
    chk("lid", 8'h00, lane_id);
    chk("res", 8'h0d, res);
    chk("sub", 8'h2f, sub);
    chk("smp", 8'h20, smp);
    chk("chks", 8'h00, chks);
    chk("ph", 8'h00, ph);
    i_host.xfer(1'b0, 13'h077, 4, 32'h5aa5c321);
    i_host.xfer(1'b0, 13'h073, 2, 32'h2e0c0000);
    wr(13'h065, 8'h5a);
    wr(13'h067, 8'h03);
    wr(13'h079, 8'hc3);
    wr(13'h08b, 8'h11);
    rd(13'h076, 8'h00);
    rd(13'h075, 8'h00);
    rd(13'h072, 8'h0c);
    chk("smp", 8'h20, smp);
    commit();
    chk("bid", 8'h5a, bank_id);
    chk("lid", 8'h03, lane_id);
    chk("res", 8'h0c, res);
    chk("sub", 8'h2e, sub);
    chk("smp", 8'h21, smp);
    chk("chks", 8'hc3, chks);
    chk("ph", 8'h11, ph);
    wr(13'h080, 8'h00);
    commit();
    chk("pdwn", 8'h00, {7'h00, pdwn});
    repeat (20) @(negedge clock);
    end_of_test();
  end
endmodule
`default_nettype wire
